//--- verilog/spi_port_regs.svh
`ifndef SPI_PORT_REGS_SVH
`define SPI_PORT_REGS_SVH

// register addresses
`define ADDR_DATA 8'h70
`define ADDR_CTRL 8'h71
`define ADDR_STAT 8'h72

// control register fields
`define CTRL_IE 7
`define CTRL_PE 6
`define CTRL_RATE2 5
`define CTRL_MASTER 4
`define CTRL_CPOL 3
`define CTRL_CPHA 2
`define CTRL_RATE_HI 1
`define CTRL_RATE_LO 0
`define CTRL_RESET 8'h00

// status register fields
`define STAT_DONE 7
`define STAT_WRITE_COLLISION_FLAG 6
`define STAT_OVR 5
`define STAT_MODE_FAULT_FLAG 4
`define STAT_RSVD 3
`define STAT_SOD 2
`define STAT_SSM 1
`define STAT_SSI 0

// serial clock half periods in system cycles, minus one
`define HALF_DIV8 7'h03
`define HALF_DIV16 7'h07
`define HALF_DIV64 7'h1f
`define HALF_DIV128 7'h3f

// clock edges per byte, bit counts
`define EDGES_LAST 5'h0f
`define EDGES_ZERO 5'h00
`define EDGE_STEP 5'h01
`define DIV_ZERO 7'h00
`define DIV_STEP 7'h01
`define BYTE_ZERO 8'h00

`endif

//--- verilog/spi_port_pkg.sv
package spi_port_pkg;

	typedef enum logic {
		MODE_IDLE,
		MODE_RUN
	} mode_t;

	typedef struct packed {
		logic [1:0] sck_s;
		logic [1:0] mosi_s;
		logic [1:0] miso_s;
		logic [1:0] ss_s;
		logic sck_d;
		logic [7:0] ctrl;
		logic transfer_done_flag;
		logic write_collision_flag;
		logic overrun_flag;
		logic mode_fault_flag;
		logic output_disable;
		logic select_soft_management;
		logic internal_select_level;
		logic stat_seen;
		logic stat_read;
		logic fault_seen;
		mode_t mode;
		logic [7:0] shifter;
		logic [7:0] rx_buf;
		logic in_bit;
		logic [4:0] edges;
		logic [6:0] div_cnt;
		logic sck_o;
		logic sck_oe;
		logic tx_bit;
		logic mosi_oe;
		logic miso_oe;
		logic irq;
		logic [7:0] rdata;
	} state_t;

endpackage : spi_port_pkg

//--- verilog/spi_status_data_port.sv
// Added by the designer: strobed register access.
`timescale 1ns/1ps
`include "spi_port_regs.svh"

// How it works
// - byte finished sets done flag, bit 7; interrupts when enabled.
// - done clears after status access then data read or write.
// - data writes ignored while done set until status has been read.
// - data write during transfer sets collision flag, bit 6; cleared by sequence.
// - byte completing while done still set raises overrun, bit 5.
// - overrun clears when software reads the status register.
// - select low while master sets mode fault, bit 4.
// - mode fault clears after status access, then a control write.
// - output-disable, bit 2, releases data output; else driven only when enabled.
// - soft select management, bit 1, ignores the select pin.
// - internal select bit 0: zero selected, one deselected.
// - master starts a byte exchange on each data write accepted while enabled and idle.
// - finished byte copied into receive buffer unless done still set; data reads return it.
// - data writes go straight into the shift register.
// - all status bits reset to zero.
// - data register content after reset is undefined.
// - one interrupt while enabled and done, fault or overrun set.
// - master mode fault clears peripheral enable and master select.
// - master clock divides system clock by 4 to 128.
module spi_status_data_port
	import spi_port_pkg::*;
(
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	output logic irq,
	input wire logic sck_in,
	output logic sck_out,
	output logic sck_oe,
	input wire logic mosi_in,
	output logic mosi_out,
	output logic mosi_oe,
	input wire logic miso_in,
	output logic miso_out,
	output logic miso_oe,
	input wire logic ss_n_in
);

	logic [1:0] rst_sync_ff;
	logic rst_n;
	state_t s_ff;
	state_t nxt_s;

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rst_sync_ff <= 2'h0;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_ff[1];

	logic wr_data, rd_data, wr_ctrl, wr_stat, rd_stat;
	logic pe, master, cpol, cpha, ss_int, selected, busy, fault;
	logic edge_now, lead, new_sck, rx_in, done_set, ovr_set;
	logic [6:0] half;
	logic [7:0] byte_in;

	always_comb begin
		nxt_s = s_ff;
		// pins cross into clk_sys through two flops; only stage 1 is read below
		nxt_s.sck_s = {s_ff.sck_s[0], sck_in};
		nxt_s.mosi_s = {s_ff.mosi_s[0], mosi_in};
		nxt_s.miso_s = {s_ff.miso_s[0], miso_in};
		nxt_s.ss_s = {s_ff.ss_s[0], ss_n_in};
		nxt_s.sck_d = s_ff.sck_s[1];

		wr_data = wr && (addr == `ADDR_DATA);
		rd_data = rd && (addr == `ADDR_DATA);
		wr_ctrl = wr && (addr == `ADDR_CTRL);
		wr_stat = wr && (addr == `ADDR_STAT);
		rd_stat = rd && (addr == `ADDR_STAT);

		pe = s_ff.ctrl[`CTRL_PE];
		master = s_ff.ctrl[`CTRL_MASTER];
		cpol = s_ff.ctrl[`CTRL_CPOL];
		cpha = s_ff.ctrl[`CTRL_CPHA];
		ss_int = s_ff.select_soft_management ? s_ff.internal_select_level : s_ff.ss_s[1];
		selected = !ss_int;
		busy = master ? (s_ff.mode == MODE_RUN) : (s_ff.edges != `EDGES_ZERO);
		fault = pe && master && !ss_int;

		unique case (s_ff.ctrl[`CTRL_RATE_HI:`CTRL_RATE_LO])
			2'h0: half = `HALF_DIV8;
			2'h1: half = `HALF_DIV16;
			2'h2: half = `HALF_DIV64;
			2'h3: half = `HALF_DIV128;
		endcase
		if (s_ff.ctrl[`CTRL_RATE2]) begin
			half = half >> 1;
		end

		// serial clock edges: generated in master mode, detected in slave mode
		edge_now = 1'b0;
		new_sck = s_ff.sck_o;
		if (master) begin
			if (s_ff.mode == MODE_RUN) begin
				if (s_ff.div_cnt == half) begin
					nxt_s.div_cnt = `DIV_ZERO;
					edge_now = 1'b1;
					new_sck = !s_ff.sck_o;
				end else begin
					nxt_s.div_cnt = s_ff.div_cnt + `DIV_STEP;
				end
			end else begin
				nxt_s.div_cnt = `DIV_ZERO;
				nxt_s.sck_o = cpol;
				new_sck = cpol;
			end
		end else begin
			new_sck = s_ff.sck_s[1];
			edge_now = pe && selected && (s_ff.sck_s[1] != s_ff.sck_d);
			nxt_s.sck_o = cpol;
		end
		lead = (new_sck != cpol);
		rx_in = master ? s_ff.miso_s[1] : s_ff.mosi_s[1];
		// master samples on the trailing edge: the synchroniser delay would otherwise catch a stale bit at /4
		byte_in = (cpha || master) ? {s_ff.shifter[6:0], rx_in} : {s_ff.shifter[6:0], s_ff.in_bit};

		done_set = 1'b0;
		ovr_set = 1'b0;
		if (edge_now) begin
			if (master) begin
				nxt_s.sck_o = new_sck;
			end
			nxt_s.edges = s_ff.edges + `EDGE_STEP;
			if (lead) begin
				if (!cpha) begin
					nxt_s.in_bit = rx_in;
				end else begin
					nxt_s.tx_bit = s_ff.shifter[7];
				end
			end else begin
				nxt_s.shifter = byte_in;
				if (!cpha) begin
					nxt_s.tx_bit = s_ff.shifter[6];
				end
			end
			if (s_ff.edges == `EDGES_LAST) begin
				nxt_s.edges = `EDGES_ZERO;
				nxt_s.mode = MODE_IDLE;
				if (s_ff.transfer_done_flag) begin
					ovr_set = 1'b1;
				end else begin
					nxt_s.rx_buf = byte_in;
					done_set = 1'b1;
				end
			end
		end
		if (!master && !(pe && selected)) begin
			// a deselected slave drops a partial byte
			nxt_s.edges = `EDGES_ZERO;
		end

		// status access arms the clear sequences
		if (rd_stat || wr_stat) begin
			nxt_s.stat_seen = 1'b1;
			if (s_ff.mode_fault_flag) begin
				nxt_s.fault_seen = 1'b1;
			end
		end
		if (rd_stat) begin
			nxt_s.stat_read = 1'b1;
			nxt_s.overrun_flag = 1'b0;
		end
		if (wr_stat) begin
			nxt_s.output_disable = wdata[`STAT_SOD];
			nxt_s.select_soft_management = wdata[`STAT_SSM];
			nxt_s.internal_select_level = wdata[`STAT_SSI];
		end

		if (rd_data || wr_data) begin
			if (s_ff.stat_seen) begin
				nxt_s.transfer_done_flag = 1'b0;
				nxt_s.write_collision_flag = 1'b0;
				nxt_s.stat_seen = 1'b0;
			end
		end
		if (wr_data && !(s_ff.transfer_done_flag && !s_ff.stat_read)) begin
			if (busy) begin
				nxt_s.write_collision_flag = 1'b1;
			end else if (pe) begin
				nxt_s.shifter = wdata;
				nxt_s.tx_bit = wdata[7];
				nxt_s.edges = `EDGES_ZERO;
				if (master) begin
					nxt_s.mode = MODE_RUN;
				end
			end
		end

		if (wr_ctrl) begin
			nxt_s.ctrl = wdata;
			if (s_ff.fault_seen) begin
				nxt_s.mode_fault_flag = 1'b0;
				nxt_s.fault_seen = 1'b0;
			end
		end

		// hardware sets come last so a set wins over a clear in the same cycle
		if (done_set) begin
			nxt_s.transfer_done_flag = 1'b1;
			nxt_s.stat_read = 1'b0;
			nxt_s.stat_seen = 1'b0;
		end
		if (ovr_set) begin
			nxt_s.overrun_flag = 1'b1;
		end
		if (fault) begin
			nxt_s.mode_fault_flag = 1'b1;
			nxt_s.ctrl[`CTRL_PE] = 1'b0;
			nxt_s.ctrl[`CTRL_MASTER] = 1'b0;
			nxt_s.mode = MODE_IDLE;
			nxt_s.edges = `EDGES_ZERO;
		end

		// pin drivers
		nxt_s.sck_oe = nxt_s.ctrl[`CTRL_PE] && nxt_s.ctrl[`CTRL_MASTER];
		nxt_s.mosi_oe = nxt_s.ctrl[`CTRL_PE] && nxt_s.ctrl[`CTRL_MASTER] && !nxt_s.output_disable;
		nxt_s.miso_oe = nxt_s.ctrl[`CTRL_PE] && !nxt_s.ctrl[`CTRL_MASTER] && !nxt_s.output_disable
			&& selected;
		nxt_s.irq = nxt_s.ctrl[`CTRL_IE] && (nxt_s.transfer_done_flag || nxt_s.mode_fault_flag
			|| nxt_s.overrun_flag);

		// read data stands one cycle after the read strobe only
		nxt_s.rdata = `BYTE_ZERO;
		if (rd) begin
			unique case (addr)
				`ADDR_DATA: nxt_s.rdata = s_ff.rx_buf;
				`ADDR_CTRL: nxt_s.rdata = s_ff.ctrl;
				`ADDR_STAT: begin
					nxt_s.rdata[`STAT_DONE] = s_ff.transfer_done_flag;
					nxt_s.rdata[`STAT_WRITE_COLLISION_FLAG] = s_ff.write_collision_flag;
					nxt_s.rdata[`STAT_OVR] = s_ff.overrun_flag;
					nxt_s.rdata[`STAT_MODE_FAULT_FLAG] = s_ff.mode_fault_flag;
					nxt_s.rdata[`STAT_RSVD] = 1'b0;
					nxt_s.rdata[`STAT_SOD] = s_ff.output_disable;
					nxt_s.rdata[`STAT_SSM] = s_ff.select_soft_management;
					nxt_s.rdata[`STAT_SSI] = s_ff.internal_select_level;
				end
				default: nxt_s.rdata = `BYTE_ZERO;
			endcase
		end
	end

	// shifter and receive buffer reset to zero only for determinism; software sees them as undefined
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign rdata = s_ff.rdata;
	assign irq = s_ff.irq;
	assign sck_out = s_ff.sck_o;
	assign sck_oe = s_ff.sck_oe;
	assign mosi_out = s_ff.tx_bit;
	assign mosi_oe = s_ff.mosi_oe;
	assign miso_out = s_ff.tx_bit;
	assign miso_oe = s_ff.miso_oe;

endmodule : spi_status_data_port

//--- dv/spi_slave_model.sv
`timescale 1ns/1ps
module spi_slave_model (
	input wire logic sck,
	input wire logic mosi,
	input wire logic sel_n,
	input wire logic [7:0] tx_byte,
	output logic miso,
	output logic [7:0] rx_byte
);
	logic [7:0] sh_ff;
	// released line shows the inverse so a stale bit never passes
	assign miso = sel_n ? ~sh_ff[7] : sh_ff[7];
	always @(negedge sel_n) sh_ff = tx_byte;
	always @(posedge sck) if (!sel_n) rx_byte = {rx_byte[6:0], mosi};
	always @(negedge sck) if (!sel_n) sh_ff = {sh_ff[6:0], 1'b0};
endmodule : spi_slave_model

//--- dv/spi_port_properties.sv
`timescale 1ns/1ps
module spi_port_properties (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic [7:0] addr,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata,
	input wire logic irq,
	input wire logic sck_out,
	input wire logic sck_oe,
	input wire logic mosi_oe,
	input wire logic miso_oe
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	sequence s_sck_edge;
		sck_oe && $changed(sck_out);
	endsequence
	property p_rsvd_zero; rd && addr == 8'h72 |=> !rdata[3]; endproperty
	property p_rdata_idle; !rd |=> rdata == 8'h00; endproperty
	property p_reset_quiet;
		disable iff (1'b0) !nrst |-> rdata == 8'h00 && !irq && !sck_oe && !mosi_oe && !miso_oe;
	endproperty
	property p_mosi_master; mosi_oe |-> sck_oe; endproperty
	property p_miso_slave; miso_oe |-> !sck_oe && !mosi_oe; endproperty
	property p_sck_half; s_sck_edge |=> $stable(sck_out); endproperty
	property p_sck_quiet; !sck_oe && !wr |=> $stable(sck_out); endproperty
	// flags only drop through a software access
	property p_irq_fall; $fell(irq) |-> $past(rd) || $past(wr) || $past(rd, 2) || $past(wr, 2); endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit set");
	a_rdata_idle: assert property (p_rdata_idle) else $error("rdata not idle");
	a_reset_quiet: assert property (p_reset_quiet) else $error("active in reset");
	a_mosi_master: assert property (p_mosi_master) else $error("mosi driven off master");
	a_miso_slave: assert property (p_miso_slave) else $error("miso driven off slave");
	a_sck_half: assert property (p_sck_half) else $error("sck half too short");
	a_sck_quiet: assert property (p_sck_quiet) else $error("sck moved undriven");
	a_irq_fall: assert property (p_irq_fall) else $error("irq fell alone");
endmodule : spi_port_properties
bind spi_status_data_port spi_port_properties u_props (.clk_sys(clk_sys), .nrst(nrst), .addr(addr), .wr(wr),
	.rd(rd), .rdata(rdata), .irq(irq), .sck_out(sck_out), .sck_oe(sck_oe), .mosi_oe(mosi_oe), .miso_oe(miso_oe));

//--- dv/tb_spi_status_data_port.sv
`timescale 1ns/1ps
`include "spi_port_regs.svh"
module tb_spi_status_data_port;
	logic clk_sys = 0, nrst = 0, wr = 0, rd = 0, ss_n_in = 0, sel_n = 1, rd_seen = 0, last = 0;
	logic [7:0] addr = 0, wdata = 0, stx = 0, rdata, srx;
	logic irq, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, miso_w;
	logic [7:0] exp_q[$];
	logic [7:0] ctl_tab[6] = '{8'hf0, 8'hd0, 8'hd1, 8'hf2, 8'hd2, 8'hd3};
	int mismatches = 0, n_tests = 0, cnt = 0, half = 0;
	spi_status_data_port u_dut (.clk_sys(clk_sys), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .irq(irq), .sck_in(1'b0), .sck_out(sck_out), .sck_oe(sck_oe), .mosi_in(1'b0),
		.mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_w), .miso_out(miso_out), .miso_oe(miso_oe),
		.ss_n_in(ss_n_in));
	spi_slave_model u_slave (.sck(sck_out), .mosi(mosi_oe ? mosi_out : ~mosi_out), .sel_n(sel_n),
		.tx_byte(stx), .miso(miso_w), .rx_byte(srx));
	initial forever #10 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		rd_seen <= rd;
		if (sck_out !== last) begin
			half <= cnt;
			cnt <= 1;
			last <= sck_out;
		end else cnt <= cnt + 1;
	end
	always @(negedge clk_sys) if (rd_seen) cmp(exp_q.pop_front(), rdata);
	task cmp(input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask : cmp
	task wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_sys);
		wr <= 1'b0;
	endtask : wr_reg
	task rd_reg(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		@(posedge clk_sys);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys);
		rd <= 1'b0;
	endtask : rd_reg
	// mode 0 plain, 1 collision mid byte, 2 data write while done still set
	task xfer(input int k, input int m);
		logic [7:0] d;
		logic [7:0] s;
		d = $urandom;
		s = $urandom;
		stx <= s;
		sel_n <= 1'b0;
		wr_reg(`ADDR_CTRL, ctl_tab[k]);
		wr_reg(`ADDR_DATA, d);
		if (m == 1) wr_reg(`ADDR_DATA, ~d);
		for (int i = 0; i < 3000 && irq !== 1'b1; i++) @(posedge clk_sys);
		cmp({7'h00, irq}, 8'h01);
		cmp(8'(half), 8'(2 << k));
		if (m == 2) wr_reg(`ADDR_DATA, d ^ 8'h0f);
		rd_reg(`ADDR_STAT, m == 1 ? 8'hc3 : 8'h83);
		rd_reg(`ADDR_DATA, s);
		sel_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		cmp(srx, d);
		cmp({7'h00, irq}, 8'h00);
	endtask : xfer
	task finish_test;
		$display("mismatches %0d n_tests %0d", mismatches, n_tests);
		if (mismatches == 0 && n_tests > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : finish_test
	initial begin
		#1_000_000;
		mismatches++;
		finish_test();
	end
	initial begin
		void'($urandom(32'h0000_169b));
		repeat (4) @(posedge clk_sys);
		nrst <= 1'b1;
		repeat (3) @(posedge clk_sys);
		rd_reg(`ADDR_STAT, 8'h00);
		rd_reg(8'h73, 8'h00);
		wr_reg(`ADDR_STAT, 8'h03);
		rd_reg(`ADDR_STAT, 8'h03);
		for (int k = 0; k < 6; k++) xfer(k, k % 3);
		wr_reg(`ADDR_STAT, 8'h00);
		repeat (10) @(posedge clk_sys);
		cmp({6'h00, irq, sck_oe}, 8'h02);
		rd_reg(`ADDR_STAT, 8'h10);
		rd_reg(`ADDR_CTRL, 8'h83);
		wr_reg(`ADDR_CTRL, 8'h00);
		rd_reg(`ADDR_STAT, 8'h00);
		repeat (3) @(posedge clk_sys);
		finish_test();
	end
endmodule : tb_spi_status_data_port
